// file: core/vme_ctrl_pkg.sv
// constants and types shared by the control-register slave files
package vme_ctrl_pkg;
	// clock and strobe timing
	localparam int CLK_PERIOD_NS  = 5;
	localparam int IRQ_STROBE_NS  = 36;
	// roughly 36 ns: rounded down, never below one cycle
	localparam int IRQ_STROBE_CYC = (IRQ_STROBE_NS / CLK_PERIOD_NS) < 1 ?
		1 : (IRQ_STROBE_NS / CLK_PERIOD_NS);
	localparam int STROBE_CNT_W   = 4;

	// address layout
	localparam int GEO_LSB        = 27;
	localparam int GEO_MSB        = 31;
	localparam int LOCAL_TGT_LSB  = 21;
	localparam int LOCAL_TGT_MSB  = 23;
	localparam int CTRL_SEL_BIT   = 23;

	// printed local offsets
	localparam logic [23:0] OFS_BUS_REQ   = 24'h800000;
	localparam logic [23:0] OFS_RST_IRQ   = 24'h800004;
	localparam logic [23:0] OFS_BOOT_SEL  = 24'h800008;
	localparam logic [23:0] OFS_INHIBIT   = 24'h80000C;
	localparam logic [23:0] OFS_OWNER_A   = 24'h810000;
	localparam logic [23:0] OFS_OWNER_B   = 24'h810004;
	localparam logic [23:0] OFS_OWNER_X   = 24'h810008;
	localparam logic [23:0] OFS_IRQ_ID    = 24'h820000;
	localparam logic [23:0] OFS_MAILBOX   = 24'h820024;

	// only A17, A16, A3, A2 reach the decoder
	function automatic logic [3:0] reg_index(input logic [23:0] a);
		reg_index = {a[17], a[16], a[3], a[2]};
	endfunction

	// data bit positions used by the narrow registers
	localparam int BIT_LO0        = 0;
	localparam int BIT_LO1        = 1;
	localparam int BIT_HI0        = 16;
	localparam int BIT_HI1        = 17;
	localparam int ID_HI_LSB      = 2;
	localparam int ID_HI_MSB      = 7;
	localparam int SERIAL_LSB     = 16;
	localparam int SERIAL_MSB     = 25;
	localparam int MBOX_LA_LSB    = 2;
	localparam int MBOX_LA_MSB    = 7;
	localparam int MBOX_SP_LSB    = 18;
	localparam int MBOX_SP_MSB    = 23;
	localparam logic [31:0] MBOX_CLR_LA = 32'h00000024;
	localparam logic [31:0] MBOX_CLR_SP = 32'h00240000;

	// interrupt handling
	localparam logic [2:0] IRQ_LEVEL   = 3'h3;
	localparam logic [1:0] SRC_LA      = 2'h1;
	localparam logic [1:0] SRC_SP      = 2'h2;

	// reset values
	localparam logic [5:0] ID_HI_RST   = 6'h00;
	localparam logic [1:0] SECTOR_RST  = 2'h0;

	// A32 address modifier codes accepted
	localparam logic [5:0] AM_A32_UD   = 6'h09;
	localparam logic [5:0] AM_A32_UP   = 6'h0A;
	localparam logic [5:0] AM_A32_SD   = 6'h0D;
	localparam logic [5:0] AM_A32_SP   = 6'h0E;

	// bus cycle handler states
	typedef enum logic [0:0] {ST_IDLE, ST_ACK} cycle_state_t;

	// lane swap between big-endian pins and internal word
	function automatic logic [31:0] swap32(input logic [31:0] d);
		swap32 = {d[7:0], d[15:8], d[23:16], d[31:24]};
	endfunction
endpackage

// file: core/strobe_if.sv
// strobe request and pulse signals between the slave and its pulse generator
`timescale 1ns/1ps
interface strobe_if;
	logic [1:0] fire;  // one-cycle launch, bit 0 logic array, bit 1 processor
	logic [1:0] pulse; // stretched strobe
	modport gen (input fire, output pulse);
	modport user (output fire, input pulse);
endinterface

// file: core/irq_strobe_gen.sv
// fixed-length interrupt strobe generator, one channel per target
`timescale 1ns/1ps
module irq_strobe_gen (
	input  wire logic i_core_clk,
	input  wire logic i_sys_rst,
	strobe_if.gen     s
);
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : ch
			// cycles left in the current strobe
			logic [vme_ctrl_pkg::STROBE_CNT_W-1:0] cnt;
			logic                                  pulse_q; // channel strobe
			// each channel owns one bit, so one process per bit
			assign s.pulse[g] = pulse_q;
			// a new launch restarts the strobe rather than extending it
			always_ff @(posedge i_core_clk) begin
				if (i_sys_rst) begin
					cnt <= '0;
					pulse_q <= 1'b0;
				end else if (s.fire[g]) begin
					cnt <= vme_ctrl_pkg::STROBE_CNT_W'(
						vme_ctrl_pkg::IRQ_STROBE_CYC - 1);
					pulse_q <= 1'b1;
				end else if (cnt != '0) begin
					cnt <= cnt - 1'b1;
				end else begin
					pulse_q <= 1'b0; // self clearing
				end
			end
			// pulse lasts exactly the strobe length
			AST_STROBE_LEN: assert property (@(posedge i_core_clk)
				disable iff (i_sys_rst)
				$rose(s.pulse[g]) && !s.fire[g] |->
				s.pulse[g] [*7] ##1 (!s.pulse[g] || $past(s.fire[g])))
				else $error("interrupt strobe length wrong");
		end
	endgenerate
endmodule

// file: core/vme_ctrl_regs.sv
// control-register slave of the VME logic module
`timescale 1ns/1ps
module vme_ctrl_regs #(
	parameter logic [9:0] SERIAL_NUMBER = 10'h155 // arbitrary value
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_sys_rst,
	input  wire logic [4:0]  i_slot_id,
	input  wire logic        i_vme_ds_n,
	input  wire logic        i_vme_iack_n,
	input  wire logic [5:0]  i_vme_am,
	input  wire logic        i_vme_lword_n,
	input  wire logic [31:1] i_vme_addr,
	input  wire logic [31:0] i_vme_data,
	output logic      [31:0] o_vme_data,
	output logic             o_vme_data_oe,
	output logic             o_vme_dtack_n,
	output logic             o_vme_irq3_n,
	input  wire logic [2:0]  i_bus_grant,
	input  wire logic [1:0]  i_bus_a_owner,
	input  wire logic [1:0]  i_bus_b_owner,
	input  wire logic [1:0]  i_bus_x_owner,
	output logic             o_request_bus_a,
	output logic             o_request_bus_b,
	output logic             o_request_bus_x,
	output logic             o_master_inhibit,
	output logic             o_logic_array_reset,
	output logic             o_signal_processor_reset,
	output logic             o_logic_array_interrupt_strobe,
	output logic             o_signal_processor_interrupt_strobe,
	output logic             o_logic_array_config_start,
	output logic [1:0]       o_boot_flash_sector,
	output logic             o_boot_from_sram_bank_a,
	input  wire logic        i_logic_array_irq,
	input  wire logic        i_signal_processor_irq,
	input  wire logic        i_la_mailbox_wr,
	input  wire logic [5:0]  i_la_mailbox_data,
	input  wire logic        i_sp_mailbox_wr,
	input  wire logic [5:0]  i_sp_mailbox_data,
	output logic             o_la_mailbox_dirty,
	output logic             o_sp_mailbox_dirty
);
	// data strobe synchroniser, third stage used for agreement
	logic         ds_s1;
	logic         ds_s2;
	logic         ds_s3;
	logic         ds_low;         // filtered strobe level
	logic         cyc_start;      // strobe newly asserted
	logic         cyc_end;        // strobe settled high
	vme_ctrl_pkg::cycle_state_t state; // bus cycle handler state

	// decoded request
	logic [23:0]  local_addr;
	logic [3:0]   idx;
	logic         am_a32;
	logic         reg_hit;        // control register access for us
	logic         iack_hit;       // our interrupt being acknowledged
	logic         wr_en;          // write accepted this cycle
	logic         sel_req;        // write hits the request register
	logic         sel_rst;        // write hits reset and strobe bits
	logic         sel_boot;       // write hits the boot selector
	logic         sel_inh;        // write hits the inhibit flag
	logic         sel_id;         // write hits the interrupt id
	logic         sel_mbox;       // write hits the mailbox clear word
	logic [31:0]  wdata;          // write word in internal order
	logic [31:0]  rword;          // register read word
	logic [7:0]   id_byte;

	// register state
	logic [5:0]   id_hi;          // programmable ID bits
	logic [5:0]   la_mailbox;
	logic [5:0]   sp_mailbox;
	logic [1:0]   sector_sel;
	logic         sram_sel;
	logic         la_reset_q;     // for reset release edge

	strobe_if strobe ();

	// stretches each one-cycle launch into the interrupt strobe
	irq_strobe_gen irq_strobe_gen_inst (
		.i_core_clk (i_core_clk),
		.i_sys_rst  (i_sys_rst),
		.s          (strobe)
	);
	assign o_logic_array_interrupt_strobe      = strobe.pulse[0];
	assign o_signal_processor_interrupt_strobe = strobe.pulse[1];
	assign sector_sel = o_boot_flash_sector;
	assign sram_sel   = o_boot_from_sram_bank_a;

	// three-stage sampling of the asynchronous strobe
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			ds_s1 <= 1'b1;
			ds_s2 <= 1'b1;
			ds_s3 <= 1'b1;
			ds_low <= 1'b0;
		end else begin
			ds_s1 <= i_vme_ds_n;
			ds_s2 <= ds_s1;
			ds_s3 <= ds_s2;
			// level changes only once second and third agree
			if (ds_s2 == ds_s3)
				ds_low <= ~ds_s3;
		end
	end

	assign cyc_start = (ds_s2 == ds_s3) && !ds_s3 && !ds_low;
	assign cyc_end   = (ds_s2 == ds_s3) && ds_s3;

	// address and data are bundled: stable while the strobe is low
	assign local_addr = {i_vme_addr[23:1], 1'b0};
	assign idx        = vme_ctrl_pkg::reg_index(local_addr);
	assign am_a32     = (i_vme_am == vme_ctrl_pkg::AM_A32_UD) ||
		(i_vme_am == vme_ctrl_pkg::AM_A32_UP) ||
		(i_vme_am == vme_ctrl_pkg::AM_A32_SD) ||
		(i_vme_am == vme_ctrl_pkg::AM_A32_SP);
	// targets in bits 23:21 with bit 23 clear belong to other blocks; 22:21 are not decoded
	assign reg_hit = am_a32 && i_vme_iack_n &&
		(i_vme_addr[vme_ctrl_pkg::GEO_MSB:vme_ctrl_pkg::GEO_LSB] ==
		i_slot_id) &&
		local_addr[vme_ctrl_pkg::CTRL_SEL_BIT];
	assign iack_hit = !i_vme_iack_n && !o_vme_irq3_n &&
		(i_vme_addr[3:1] == vme_ctrl_pkg::IRQ_LEVEL);
	// no write line reaches us: every accepted register access also writes
	assign wr_en = (state == vme_ctrl_pkg::ST_IDLE) && cyc_start &&
		reg_hit;
	assign sel_req  = wr_en &&
		(idx == vme_ctrl_pkg::reg_index(vme_ctrl_pkg::OFS_BUS_REQ));
	assign sel_rst  = wr_en &&
		(idx == vme_ctrl_pkg::reg_index(vme_ctrl_pkg::OFS_RST_IRQ));
	assign sel_boot = wr_en &&
		(idx == vme_ctrl_pkg::reg_index(vme_ctrl_pkg::OFS_BOOT_SEL));
	assign sel_inh  = wr_en &&
		(idx == vme_ctrl_pkg::reg_index(vme_ctrl_pkg::OFS_INHIBIT));
	assign sel_id   = wr_en &&
		(idx == vme_ctrl_pkg::reg_index(vme_ctrl_pkg::OFS_IRQ_ID));
	assign sel_mbox = wr_en &&
		(idx == vme_ctrl_pkg::reg_index(vme_ctrl_pkg::OFS_MAILBOX));

	// write word: 16-bit cycles fill the addressed half, other half zero
	always_comb begin
		if (!i_vme_lword_n)
			wdata = vme_ctrl_pkg::swap32(i_vme_data);
		else if (i_vme_addr[1])
			wdata = {16'h0000, i_vme_data[7:0], i_vme_data[15:8]};
		else
			wdata = {i_vme_data[7:0], i_vme_data[15:8], 16'h0000};
	end

	// source bits: logic array first, processor otherwise
	assign id_byte = {id_hi, i_logic_array_irq ?
		vme_ctrl_pkg::SRC_LA : vme_ctrl_pkg::SRC_SP};

	// read multiplexer; unlisted slots read zero
	always_comb begin
		rword = 32'h00000000;
		unique case (idx)
			vme_ctrl_pkg::reg_index(vme_ctrl_pkg::OFS_BUS_REQ): begin
				rword[vme_ctrl_pkg::BIT_LO0] = i_bus_grant[0];
				rword[vme_ctrl_pkg::BIT_LO1] = i_bus_grant[1];
				rword[vme_ctrl_pkg::BIT_HI0] = i_bus_grant[2];
			end
			vme_ctrl_pkg::reg_index(vme_ctrl_pkg::OFS_BOOT_SEL): begin
				rword[vme_ctrl_pkg::BIT_LO1:vme_ctrl_pkg::BIT_LO0] =
					sector_sel;
				rword[vme_ctrl_pkg::BIT_HI0] = sram_sel;
			end
			vme_ctrl_pkg::reg_index(vme_ctrl_pkg::OFS_INHIBIT):
				rword[vme_ctrl_pkg::BIT_LO0] = o_master_inhibit;
			vme_ctrl_pkg::reg_index(vme_ctrl_pkg::OFS_OWNER_A):
				rword[1:0] = i_bus_a_owner;
			vme_ctrl_pkg::reg_index(vme_ctrl_pkg::OFS_OWNER_B):
				rword[1:0] = i_bus_b_owner;
			vme_ctrl_pkg::reg_index(vme_ctrl_pkg::OFS_OWNER_X):
				rword[1:0] = i_bus_x_owner;
			vme_ctrl_pkg::reg_index(vme_ctrl_pkg::OFS_IRQ_ID): begin
				rword[7:0] = id_byte;
				rword[vme_ctrl_pkg::SERIAL_MSB:vme_ctrl_pkg::SERIAL_LSB] =
					SERIAL_NUMBER;
			end
			vme_ctrl_pkg::reg_index(vme_ctrl_pkg::OFS_MAILBOX): begin
				rword[vme_ctrl_pkg::MBOX_LA_MSB:vme_ctrl_pkg::MBOX_LA_LSB] =
					la_mailbox;
				rword[vme_ctrl_pkg::MBOX_SP_MSB:vme_ctrl_pkg::MBOX_SP_LSB] =
					sp_mailbox;
			end
			default: rword = 32'h00000000; // write-only and unlisted
		endcase
	end

	// bus cycle handler: answer, then hold until the strobe lifts
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			state <= vme_ctrl_pkg::ST_IDLE;
			o_vme_dtack_n <= 1'b1;
			o_vme_data_oe <= 1'b0;
			o_vme_data <= 32'h00000000;
		end else begin
			unique case (state)
				vme_ctrl_pkg::ST_IDLE: begin
					if (cyc_start && (reg_hit || iack_hit)) begin
						state <= vme_ctrl_pkg::ST_ACK;
						o_vme_dtack_n <= 1'b0;
						o_vme_data_oe <= 1'b1; // drive while acknowledged
						if (iack_hit)
							o_vme_data <= {24'h000000, id_byte};
						else if (!i_vme_lword_n)
							o_vme_data <= vme_ctrl_pkg::swap32(rword);
						else if (i_vme_addr[1])
							o_vme_data <= {16'h0000, rword[7:0],
								rword[15:8]};
						else
							o_vme_data <= {16'h0000, rword[23:16],
								rword[31:24]};
					end
				end
				vme_ctrl_pkg::ST_ACK: begin
					if (cyc_end) begin
						state <= vme_ctrl_pkg::ST_IDLE;
						o_vme_dtack_n <= 1'b1;
						o_vme_data_oe <= 1'b0;
					end
				end
			endcase
		end
	end

	// host bus requests: one write replaces all three bits
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			o_request_bus_a <= 1'b0;
			o_request_bus_b <= 1'b0;
			o_request_bus_x <= 1'b0;
		end else if (sel_req) begin
			o_request_bus_a <= wdata[vme_ctrl_pkg::BIT_LO0];
			o_request_bus_b <= wdata[vme_ctrl_pkg::BIT_LO1];
			o_request_bus_x <= wdata[vme_ctrl_pkg::BIT_HI0];
		end
	end

	// resets held as written, strobes launched for one cycle
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			o_logic_array_reset <= 1'b0;
			o_signal_processor_reset <= 1'b0;
			strobe.fire <= 2'h0;
		end else begin
			strobe.fire <= 2'h0; // launch lasts a single cycle
			if (sel_rst) begin
				o_logic_array_reset <= wdata[vme_ctrl_pkg::BIT_LO0];
				o_signal_processor_reset <= wdata[vme_ctrl_pkg::BIT_LO1];
				strobe.fire <= {wdata[vme_ctrl_pkg::BIT_HI1],
					wdata[vme_ctrl_pkg::BIT_HI0]};
			end
		end
	end

	// reset release edge starts configuration from the held source
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			la_reset_q <= 1'b0;
			o_logic_array_config_start <= 1'b0;
		end else begin
			la_reset_q <= o_logic_array_reset;
			o_logic_array_config_start <= la_reset_q &&
				!o_logic_array_reset;
		end
	end

	// host settings: boot source, inhibit flag, interrupt id bits
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			o_boot_flash_sector <= vme_ctrl_pkg::SECTOR_RST;
			o_boot_from_sram_bank_a <= 1'b0;
			o_master_inhibit <= 1'b0;
			id_hi <= vme_ctrl_pkg::ID_HI_RST;
		end else begin
			if (sel_boot) begin
				// sector kept as written; the sram flag outranks it
				o_boot_flash_sector <= wdata[vme_ctrl_pkg::BIT_LO1:
					vme_ctrl_pkg::BIT_LO0];
				o_boot_from_sram_bank_a <= wdata[vme_ctrl_pkg::BIT_HI0];
			end
			if (sel_inh)
				o_master_inhibit <= wdata[vme_ctrl_pkg::BIT_LO0];
			if (sel_id)
				id_hi <= wdata[vme_ctrl_pkg::ID_HI_MSB:
					vme_ctrl_pkg::ID_HI_LSB];
		end
	end

	// mailboxes: a post in the same cycle as a clear wins
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			la_mailbox <= 6'h00;
			sp_mailbox <= 6'h00;
			o_la_mailbox_dirty <= 1'b0;
			o_sp_mailbox_dirty <= 1'b0;
		end else begin
			if (i_la_mailbox_wr) begin
				la_mailbox <= i_la_mailbox_data;
				o_la_mailbox_dirty <= 1'b1;
			end else if (sel_mbox && ((wdata & vme_ctrl_pkg::MBOX_CLR_LA) ==
				vme_ctrl_pkg::MBOX_CLR_LA)) begin
				la_mailbox <= 6'h00;
				o_la_mailbox_dirty <= 1'b0;
			end
			if (i_sp_mailbox_wr) begin
				sp_mailbox <= i_sp_mailbox_data;
				o_sp_mailbox_dirty <= 1'b1;
			end else if (sel_mbox && ((wdata & vme_ctrl_pkg::MBOX_CLR_SP) ==
				vme_ctrl_pkg::MBOX_CLR_SP)) begin
				sp_mailbox <= 6'h00;
				o_sp_mailbox_dirty <= 1'b0;
			end
		end
	end

	// interrupt request line follows the two internal sources
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst)
			o_vme_irq3_n <= 1'b1;
		else
			o_vme_irq3_n <= !(i_logic_array_irq || i_signal_processor_irq);
	end

	// checks, all in the core clock domain
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);
	sequence s_taken;
		(state == vme_ctrl_pkg::ST_IDLE) && cyc_start && (reg_hit || iack_hit);
	endsequence
	sequence s_lifted;
		(state == vme_ctrl_pkg::ST_ACK) && cyc_end;
	endsequence
	AST_DTACK_ON_TAKE: assert property (s_taken |=> !o_vme_dtack_n)
		else $error("acknowledge missing after accepted cycle");
	AST_DTACK_RELEASE: assert property (s_lifted |=> o_vme_dtack_n)
		else $error("acknowledge not lifted after strobe");
	AST_REQ_ALL_BITS: assert property (sel_req |=>
		o_request_bus_a == $past(wdata[0]) &&
		o_request_bus_b == $past(wdata[1]) &&
		o_request_bus_x == $past(wdata[16]))
		else $error("request bits not replaced together");
	AST_RESET_HOLDS: assert property (o_logic_array_reset && !sel_rst |=>
		o_logic_array_reset)
		else $error("array reset dropped without a write");
	AST_BOOT_ON_RELEASE: assert property ($fell(o_logic_array_reset) |=>
		o_logic_array_config_start)
		else $error("no configuration start after reset release");
	AST_MBOX_SET_WINS: assert property (i_la_mailbox_wr |=>
		o_la_mailbox_dirty)
		else $error("mailbox post did not raise dirty flag");
endmodule

// file: dv/vme_host_model.sv
// host-side bus master that drives the control-register slave
`timescale 1ns/1ps
module vme_host_model (
	input  wire logic        i_core_clk,
	input  wire logic        i_dtack_n,
	input  wire logic [31:0] i_slave_data,
	input  wire logic        i_slave_oe,
	output logic             o_ds_n,
	output logic             o_iack_n,
	output logic [5:0]       o_am,
	output logic             o_lword_n,
	output logic [31:1]      o_addr,
	output logic [31:0]      o_data
);
	logic [4:0]  geo = 5'h0B;                   // slot presented
	logic [5:0]  mod = vme_ctrl_pkg::AM_A32_UD; // modifier presented
	logic [31:0] drv = 32'h0;                   // host level on data pins
	// slave wins the data pins while it drives them
	assign o_data = i_slave_oe ? i_slave_data : drv;
	// idle bus at time zero
	initial begin
		o_ds_n = 1'b1;
		o_iack_n = 1'b1;
		o_am = mod;
		o_lword_n = 1'b0;
		o_addr = '0;
	end
	// word MSB byte travels on D0-D7
	function automatic logic [31:0] lanes(input logic [31:0] d);
		return {d[7:0], d[15:8], d[23:16], d[31:24]};
	endfunction
	// one cycle; ok stays low if no acknowledge within 16 edges
	task automatic cyc(input logic ack, input logic [23:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic ok);
		int n;
		ok = 1'b0;
		q = '0;
		@(posedge i_core_clk);
		#1;
		o_iack_n = ~ack;
		o_am = mod;
		// bits 24-26 always zero in a full address
		o_addr = ack ? {28'h0, 3'h3} : {geo, 3'h0, a[23:1]};
		drv = ack ? ~drv : lanes(d);
		o_ds_n = 1'b0;
		for (n = 0; n < 16 && !ok; n++) begin
			@(posedge i_core_clk);
			if (i_dtack_n === 1'b0) begin
				ok = 1'b1;
				q = ack ? i_slave_data : lanes(i_slave_data);
			end
		end
		#1;
		o_ds_n = 1'b1;
		o_iack_n = 1'b1;
		drv = ~drv; // released lines lose the old value
		for (n = 0; n < 16 && i_dtack_n !== 1'b1; n++)
			@(posedge i_core_clk);
		#1;
	endtask
endmodule

// file: dv/vme_slave_control_registers_bench.sv
// bench: register accesses through the host model, checked at the pins
`timescale 1ns/1ps
module vme_slave_control_registers_bench;
	localparam logic [9:0] SN = 10'h2A3; // arbitrary serial value
	logic        i_core_clk, i_sys_rst, i_vme_ds_n, i_vme_iack_n;
	logic        i_vme_lword_n, o_vme_data_oe, o_vme_dtack_n, o_vme_irq3_n;
	logic [4:0]  i_slot_id;
	logic [5:0]  i_vme_am, i_la_mailbox_data, i_sp_mailbox_data;
	logic [31:1] i_vme_addr;
	logic [31:0] i_vme_data, o_vme_data, q;
	logic [2:0]  i_bus_grant;
	logic [1:0]  i_bus_a_owner, i_bus_b_owner, i_bus_x_owner;
	logic [1:0]  o_boot_flash_sector;
	logic        o_request_bus_a, o_request_bus_b, o_request_bus_x, ok;
	logic        o_master_inhibit, o_logic_array_reset;
	logic        o_signal_processor_reset, o_logic_array_interrupt_strobe;
	logic        o_signal_processor_interrupt_strobe;
	logic        o_logic_array_config_start, o_boot_from_sram_bank_a;
	logic        i_logic_array_irq, i_signal_processor_irq;
	logic        i_la_mailbox_wr, i_sp_mailbox_wr;
	logic        o_la_mailbox_dirty, o_sp_mailbox_dirty;
	int          fail_count = 0, num_checks = 0, nla, nsp, ncfg, k;

	vme_ctrl_regs #(.SERIAL_NUMBER(SN)) vme_ctrl_regs_inst (
		.i_core_clk, .i_sys_rst, .i_slot_id, .i_vme_ds_n, .i_vme_iack_n,
		.i_vme_am, .i_vme_lword_n, .i_vme_addr, .i_vme_data, .o_vme_data,
		.o_vme_data_oe, .o_vme_dtack_n, .o_vme_irq3_n, .i_bus_grant,
		.i_bus_a_owner, .i_bus_b_owner, .i_bus_x_owner, .o_request_bus_a,
		.o_request_bus_b, .o_request_bus_x, .o_master_inhibit,
		.o_logic_array_reset, .o_signal_processor_reset,
		.o_logic_array_interrupt_strobe, .o_signal_processor_interrupt_strobe,
		.o_logic_array_config_start, .o_boot_flash_sector,
		.o_boot_from_sram_bank_a, .i_logic_array_irq, .i_signal_processor_irq,
		.i_la_mailbox_wr, .i_la_mailbox_data, .i_sp_mailbox_wr,
		.i_sp_mailbox_data, .o_la_mailbox_dirty, .o_sp_mailbox_dirty);

	vme_host_model vme_host_model_inst (
		.i_core_clk, .i_dtack_n(o_vme_dtack_n), .i_slave_data(o_vme_data),
		.i_slave_oe(o_vme_data_oe), .o_ds_n(i_vme_ds_n),
		.o_iack_n(i_vme_iack_n), .o_am(i_vme_am), .o_lword_n(i_vme_lword_n),
		.o_addr(i_vme_addr), .o_data(i_vme_data));

	// 200 MHz clock
	initial begin
		i_core_clk = 1'b0;
		forever #2.5 i_core_clk = ~i_core_clk;
	end
	// closing report, the single end of the run
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// value compare and flag compare
	task automatic chk_w(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_b(input string nm, input logic e, input logic g);
		chk_w(nm, {31'h0, e}, {31'h0, g});
	endtask
	// a missing acknowledge ends the run
	task automatic wr(input logic [23:0] a, input logic [31:0] d);
		vme_host_model_inst.cyc(1'b0, a, d, q, ok);
		chk_b("dtack", 1'b1, ok);
		if (ok !== 1'b1) print_verdict();
	endtask
	// read holding h on idle pins, masked compare
	task automatic rc(input logic [23:0] a, input logic [31:0] h,
		input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
		wr(a, h);
		chk_w($sformatf("read %h", a), e, q & m);
	endtask
	// counts strobe and boot-start cycles while a write runs
	task automatic watch();
		nla = 0;
		nsp = 0;
		ncfg = 0;
		repeat (40) begin
			@(posedge i_core_clk);
			nla += int'(o_logic_array_interrupt_strobe === 1'b1);
			nsp += int'(o_signal_processor_interrupt_strobe === 1'b1);
			ncfg += int'(o_logic_array_config_start === 1'b1);
		end
	endtask
	// hang guard
	initial begin
		repeat (20000) @(posedge i_core_clk);
		fail_count++;
		print_verdict();
	end
	// iack cycle, expecting the id byte on D0-D7
	task automatic ack_id(input logic [7:0] e);
		for (k = 0; k < 50 && o_vme_irq3_n !== 1'b0; k++)
			@(posedge i_core_clk);
		vme_host_model_inst.cyc(1'b1, 24'h0, 32'h0, q, ok);
		chk_b("iack", 1'b1, ok);
		chk_w("id byte", {24'h0, e}, {24'h0, q[7:1], q[0] & e[1]});
		$display("test iack done");
	endtask

	initial begin
		i_sys_rst = 1'b1;
		i_slot_id = 5'h0B;
		i_bus_grant = 3'h0;
		{i_bus_a_owner, i_bus_b_owner, i_bus_x_owner} = 6'h00;
		{i_logic_array_irq, i_signal_processor_irq} = 2'h0;
		{i_la_mailbox_wr, i_sp_mailbox_wr} = 2'h0;
		i_la_mailbox_data = 6'h15;
		i_sp_mailbox_data = 6'h0A;
		repeat (10) @(posedge i_core_clk);
		#1 i_sys_rst = 1'b0;
		wr(24'h800000, 32'h00010003);
		wr(24'h800000, 32'h00000002);
		chk_w("reqs", 32'h2, {o_request_bus_x, o_request_bus_b,
			o_request_bus_a});
		i_bus_grant = 3'h5;
		rc(24'h800000, 32'h2, 32'h00010001);
		$display("test request done");
		fork
			wr(24'h800004, 32'h00030001);
			watch();
		join
		chk_w("resets", 32'h1, {o_signal_processor_reset,
			o_logic_array_reset});
		chk_w("la strobe", vme_ctrl_pkg::IRQ_STROBE_CYC, nla);
		chk_w("sp strobe", vme_ctrl_pkg::IRQ_STROBE_CYC, nsp);
		fork
			wr(24'h800004, 32'h00000002);
			watch();
		join
		chk_w("resets", 32'h2, {o_signal_processor_reset,
			o_logic_array_reset});
		chk_b("boot start", 1'b1, ncfg > 0);
		wr(24'h800004, 32'h0);
		$display("test reset done");
		for (int s = 0; s < 4; s++) begin
			wr(24'h800008, s);
			chk_w("sector", s, o_boot_flash_sector);
			rc(24'h800008, s, s);
		end
		wr(24'h800008, 32'h00010002);
		chk_b("sram", 1'b1, o_boot_from_sram_bank_a);
		rc(24'h800008, 32'h00010002, 32'h00010002);
		wr(24'h80000C, 32'h1);
		chk_b("inhibit", 1'b1, o_master_inhibit);
		rc(24'h80000C, 32'h1, 32'h1);
		$display("test boot done");
		for (int o = 0; o < 4; o++) begin
			{i_bus_a_owner, i_bus_b_owner, i_bus_x_owner} = {2'(o), ~2'(o),
				2'(o)};
			rc(24'h810000, 32'h0, o);
			rc(24'h810004, 32'h0, 3 - o);
			rc(24'h810008, 32'h0, o);
		end
		wr(24'h820000, 32'h000000A8);
		rc(24'h820000, 32'hA8, {6'h0, SN, 16'h00A8}, 32'hFFFFFFFC);
		i_logic_array_irq = 1'b1;
		ack_id(8'hA8);
		i_logic_array_irq = 1'b0;
		i_signal_processor_irq = 1'b1;
		ack_id(8'hAA);
		i_signal_processor_irq = 1'b0;
		{i_la_mailbox_wr, i_sp_mailbox_wr} = 2'h3;
		@(posedge i_core_clk);
		#1 {i_la_mailbox_wr, i_sp_mailbox_wr} = 2'h0;
		rc(24'h820024, 32'h0, 32'h00280054);
		wr(24'h820024, 32'h24);
		rc(24'h820024, 32'h0, 32'h00280000);
		chk_w("dirty", 32'h2, {o_sp_mailbox_dirty, o_la_mailbox_dirty});
		wr(24'h820024, 32'h00240000);
		rc(24'h820024, 32'h0, 32'h0);
		chk_b("sp dirty", 1'b0, o_sp_mailbox_dirty);
		$display("test mailbox done");
		wr(24'h81000C, 32'hFFFFFFFF);
		rc(24'h81000C, 32'h0, 32'h0);
		vme_host_model_inst.geo = 5'h0C;
		vme_host_model_inst.cyc(1'b0, 24'h800000, 32'h0, q, ok);
		chk_b("foreign slot", 1'b0, ok);
		vme_host_model_inst.geo = 5'h0B;
		vme_host_model_inst.mod = 6'h39;
		vme_host_model_inst.cyc(1'b0, 24'h800000, 32'h0, q, ok);
		chk_b("short address", 1'b0, ok);
		chk_b("req_b kept", 1'b1, o_request_bus_b);
		$display("test decode done");
		print_verdict();
	end
endmodule
